// *** irq_pin_pkg.sv ***
// Constants and types for the external interrupt pin logic
package irq_pin_pkg;
   localparam int NUM_CORE_IRQ = 16;
   localparam int NUM_EXT = 4;
   localparam int NUM_W = 4;
   localparam int SEL_W = 5;
   localparam logic [NUM_W-1:0] IDX_RESET = 4'h0;
   localparam logic [NUM_W-1:0] IDX_NMI = 4'h1;
   localparam logic [NUM_W-1:0] IDX_EXT_BASE = 4'h4;
   localparam logic [SEL_W-1:0] SEL_EXT_BASE = 5'h04;
   localparam logic [NUM_W-1:0] NUM_RESET_VAL = 4'h0;
   localparam logic [NUM_EXT-1:0] POL_RESET_VAL = 4'h0;
   localparam int SYNC_STAGES = 2;
   localparam int NMASK_LAST = 3;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACK = 2'b01
   } svc_state_t;
endpackage : irq_pin_pkg

// *** irq_edge_catch.sv ***
// Synchroniser and polarity-selectable edge detector for one pin
`timescale 1ns/10ps
`default_nettype none
module irq_edge_catch
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // Pin and edge choice (1 = falling)
   input wire logic pin_in,
   input wire logic falling_in,
   // One-cycle edge pulse
   output logic edge_out
);
   logic sync_a;
   logic sync_b;
   logic last;

   // Two stages; only sync_b is looked at
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         last <= 1'b0;
      end
      else
      begin
         sync_a <= pin_in;
         sync_b <= sync_a;
         last <= sync_b;
      end
   end

   always_comb
   begin
      edge_out = falling_in ? (last & ~sync_b) : (~last & sync_b);
   end
endmodule : irq_edge_catch
`default_nettype wire

// *** ext_irq_pin_logic.sv ***
// Pin-level interrupt logic: edge capture, pending flags, ack and number
// What this block does
// - Nonmaskable request is caught only on a rising edge, never on level.
// - Four external inputs edge-triggered, each edge chosen by polarity bit.
// - Acknowledge asserts whenever the core starts servicing any interrupt.
// - While acknowledge is high, four-bit number names the serviced interrupt.
// - Number equals the interrupt's position in the service fetch table.
// - Sixteen priorities; 0 reset highest, 15 lowest; 0 to 3 nonmaskable.
// - After reset external inputs map to 4..7 (selectors 4..7), NMI to 1.
`timescale 1ns/10ps
`default_nettype none
module ext_irq_pin_logic
   import irq_pin_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // Interrupt pins
   input wire logic nmi_pin_in,
   input wire logic ext_irq_pin_a,
   input wire logic ext_irq_pin_b,
   input wire logic ext_irq_pin_c,
   input wire logic ext_irq_pin_d,
   // Edge polarity per external input (1 = falling)
   input wire logic [irq_pin_pkg::NUM_EXT-1:0] ext_irq_edge_polarity,
   // Core side
   input wire logic [irq_pin_pkg::NUM_CORE_IRQ-1:0] irq_enable_in,
   input wire logic [irq_pin_pkg::NUM_CORE_IRQ-1:0] pending_clear_in,
   input wire logic service_take_in,
   output logic [irq_pin_pkg::NUM_CORE_IRQ-1:0] pending_out,
   output logic irq_request_out,
   // Acknowledge and number pins
   output logic irq_service_ack_out,
   output logic serviced_irq_number_b3,
   output logic serviced_irq_number_b2,
   output logic serviced_irq_number_b1,
   output logic serviced_irq_number_b0
);
   import irq_pin_pkg::*;

   logic [NUM_EXT-1:0] ext_pins;
   logic [NUM_EXT-1:0] ext_edge;
   logic nmi_edge;
   logic [NUM_CORE_IRQ-1:0] raw_set;
   logic [NUM_CORE_IRQ-1:0] pending;
   logic [NUM_CORE_IRQ-1:0] eligible;
   logic [NUM_W-1:0] top_idx;
   logic top_valid;
   logic [NUM_W-1:0] number;
   logic [NUM_CORE_IRQ-1:0] svc_clear;
   svc_state_t state;
   logic take_now;

   // Highest priority = lowest index
   function automatic logic [NUM_W-1:0] pick(
      input logic [NUM_CORE_IRQ-1:0] req);
      logic [NUM_W-1:0] idx;
      idx = '0;
      for (int i = NUM_CORE_IRQ - 1; i >= 0; i--)
      begin
         if (req[i])
         begin
            idx = NUM_W'(i);
         end
      end
      return idx;
   endfunction : pick

   assign ext_pins = {ext_irq_pin_d, ext_irq_pin_c, ext_irq_pin_b,
                      ext_irq_pin_a};

   irq_edge_catch u_nmi
   (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .pin_in(nmi_pin_in),
      .falling_in(1'b0),
      .edge_out(nmi_edge)
   );

   genvar g;
   generate
      for (g = 0; g < NUM_EXT; g++)
      begin : g_ext
         irq_edge_catch u_ext
         (
            .clk_in(clk_in),
            .srst_in(srst_in),
            .pin_in(ext_pins[g]),
            .falling_in(ext_irq_edge_polarity[g]),
            .edge_out(ext_edge[g])
         );
      end
   endgenerate

   // Default routing: NMI at 1, external at 4..7
   always_comb
   begin
      raw_set = '0;
      raw_set[IDX_NMI] = nmi_edge;
      for (int k = 0; k < NUM_EXT; k++)
      begin
         raw_set[int'(IDX_EXT_BASE) + k] = ext_edge[k];
      end
   end

   // Indices 0..3 ignore the enable mask
   always_comb
   begin
      for (int k = 0; k < NUM_CORE_IRQ; k++)
      begin
         eligible[k] = pending[k] & ((k <= NMASK_LAST) | irq_enable_in[k]);
      end
      top_valid = |eligible;
      top_idx = pick(eligible);
   end

   assign take_now = (state == ST_IDLE) && service_take_in && top_valid;

   always_comb
   begin
      svc_clear = '0;
      if (take_now)
      begin
         svc_clear[top_idx] = 1'b1;
      end
   end

   // Set wins over clear
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         pending <= '0;
      end
      else
      begin
         pending <= (pending & ~(pending_clear_in | svc_clear)) | raw_set;
      end
   end

   // Ack for one cycle per serviced interrupt
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         state <= ST_IDLE;
         number <= NUM_RESET_VAL;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               if (service_take_in && top_valid)
               begin
                  state <= ST_ACK;
                  number <= top_idx;
               end
            end
            ST_ACK:
            begin
               state <= ST_IDLE;
            end
            default:
            begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         pending_out <= '0;
         irq_request_out <= 1'b0;
      end
      else
      begin
         pending_out <= pending;
         irq_request_out <= top_valid;
      end
   end

   // Ack pulse straight from its own flop
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         irq_service_ack_out <= 1'b0;
      end
      else
      begin
         irq_service_ack_out <= take_now;
      end
   end

   assign serviced_irq_number_b3 = number[3];
   assign serviced_irq_number_b2 = number[2];
   assign serviced_irq_number_b1 = number[1];
   assign serviced_irq_number_b0 = number[0];

   // Core starts a service in this cycle
   sequence take_s;
      state == ST_IDLE && service_take_in && top_valid;
   endsequence

   // Pin went low to high three and two edges back
   sequence nmi_pin_rose_s;
      $past(nmi_pin_in, 2) && !$past(nmi_pin_in, 3);
   endsequence

   property ack_one_cycle;
      @(posedge clk_in) disable iff (srst_in)
      irq_service_ack_out |=> !irq_service_ack_out;
   endproperty
   ack_pulse_a: assert property (ack_one_cycle)
      else $error("ack longer than one cycle");

   ack_on_take_a: assert property (
      @(posedge clk_in) disable iff (srst_in)
      take_s |=> irq_service_ack_out)
      else $error("ack missing after service start");

   number_match_a: assert property (
      @(posedge clk_in) disable iff (srst_in)
      take_s |=> number == $past(top_idx))
      else $error("wrong serviced number");

   nmi_edge_a: assert property (
      @(posedge clk_in) disable iff (srst_in)
      nmi_edge |-> nmi_pin_rose_s)
      else $error("nmi request without rising edge");

   nmi_level_a: assert property (
      @(posedge clk_in) disable iff (srst_in)
      nmi_edge |=> !nmi_edge)
      else $error("nmi level repeated request");

   ext_pend_a: assert property (
      @(posedge clk_in) disable iff (srst_in)
      ext_edge[0] |=> pending[4])
      else $error("external edge not latched at index 4");

   prio_order_a: assert property (
      @(posedge clk_in) disable iff (srst_in)
      (top_valid && eligible[1]) |-> top_idx <= IDX_NMI)
      else $error("priority order broken");

   pend_hold_a: assert property (
      @(posedge clk_in) disable iff (srst_in)
      (pending[5] && !pending_clear_in[5] && !svc_clear[5])
      |=> pending[5])
      else $error("pending dropped without clear");
endmodule : ext_irq_pin_logic
`default_nettype wire

// *** irq_src_model.sv ***
// Model of the external devices that drive the interrupt lines
`timescale 1ns/10ps
`default_nettype none
module irq_src_model
(
   // Clock
   input wire logic clk_in,
   // Lines: bit 4 nonmaskable, bits 3..0 pins d..a
   output logic [4:0] line_out
);
   initial line_out = 5'h00;
   // Levels move only at the falling edge
   task drive(input int k, input logic v);
      @(negedge clk_in);
      line_out[k] = v;
   endtask : drive
endmodule : irq_src_model
`default_nettype wire

// *** tb_ext_irq_pin_logic.sv ***
// Self-checking bench for the external interrupt pin logic
`timescale 1ns/10ps
`default_nettype none
module tb_ext_irq_pin_logic;
   import irq_pin_pkg::*;
   logic clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic [NUM_EXT-1:0] pol = 4'h0;
   logic [NUM_CORE_IRQ-1:0] en = 16'hffff;
   logic [NUM_CORE_IRQ-1:0] clr = 16'h0000;
   logic take = 1'b0;
   wire logic [4:0] line;
   wire logic [NUM_CORE_IRQ-1:0] pend;
   wire logic req, ack, n3, n2, n1, n0;
   int bad_count = 0;
   int n_compared = 0;
   int mp = 0;
   int k;
   int svc_q[$];
   always #2 clk_in = ~clk_in;
   irq_src_model irq_src_model_inst (.clk_in(clk_in), .line_out(line));
   ext_irq_pin_logic ext_irq_pin_logic_inst (.clk_in(clk_in),
      .srst_in(srst_in), .nmi_pin_in(line[4]), .ext_irq_pin_a(line[0]),
      .ext_irq_pin_b(line[1]), .ext_irq_pin_c(line[2]),
      .ext_irq_pin_d(line[3]), .ext_irq_edge_polarity(pol),
      .irq_enable_in(en), .pending_clear_in(clr), .service_take_in(take),
      .pending_out(pend), .irq_request_out(req),
      .irq_service_ack_out(ack), .serviced_irq_number_b3(n3),
      .serviced_irq_number_b2(n2), .serviced_irq_number_b1(n1),
      .serviced_irq_number_b0(n0));
   task stop_test();
      $display("compared %0d bad %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("BAD %0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk
   task wait_n(input int n);
      repeat (n) @(negedge clk_in);
   endtask : wait_n
   // Reference choice: lowest index pending and eligible
   function automatic int top_idx();
      for (int i = 0; i < NUM_CORE_IRQ; i++)
         if (mp[i] && (i <= NMASK_LAST || en[i] === 1'b1))
            return i;
      return -1;
   endfunction : top_idx
   task svc();
      int e;
      e = top_idx();
      svc_q.push_back(e);
      take = 1'b1;
      @(negedge clk_in);
      take = 1'b0;
      chk(ack, 1'b1);
      chk({n3, n2, n1, n0}, 16'(svc_q.pop_front()));
      mp[e] = 0;
      wait_n(2);
      chk(ack, 1'b0);
      chk(pend, mp[15:0]);
   endtask : svc
   // Each pin: trigger edge sets, return edge does not; then service all
   task edge_round();
      for (int j = 0; j < NUM_EXT; j++)
      begin
         irq_src_model_inst.drive(j, ~pol[j]);
         wait_n(6);
         mp[4 + j] = 1;
         chk(pend, mp[15:0]);
         irq_src_model_inst.drive(j, pol[j]);
         wait_n(6);
         chk(pend, mp[15:0]);
      end
      chk(req, 1'b1);
      repeat (4) svc();
   endtask : edge_round
   initial
   begin
      #20000;
      bad_count++;
      stop_test();
   end
   initial
   begin
      pol = 4'($urandom(60357));
      for (k = 0; k < 4; k++)
         irq_src_model_inst.drive(k, pol[k]);
      wait_n(2);
      srst_in = 1'b0;
      wait_n(1);
      chk(pend, 16'h0000);
      chk({ack, n3, n2, n1, n0}, 16'h0000);
      $display("test reset done");
      edge_round();
      $display("test edges done");
      // Flip every polarity; pins move the non-triggering way
      pol = ~pol;
      for (k = 0; k < 4; k++)
         irq_src_model_inst.drive(k, pol[k]);
      wait_n(6);
      chk(pend, mp[15:0]);
      edge_round();
      $display("test polarity done");
      irq_src_model_inst.drive(4, 1'b1);
      irq_src_model_inst.drive(0, ~pol[0]);
      wait_n(6);
      mp[1] = 1;
      mp[4] = 1;
      chk(pend, mp[15:0]);
      svc();
      wait_n(6);
      chk(pend, mp[15:0]);
      irq_src_model_inst.drive(4, 1'b0);
      wait_n(6);
      chk(pend, mp[15:0]);
      $display("test nmi done");
      en[4] = 1'b0;
      wait_n(2);
      chk(req, 1'b0);
      take = 1'b1;
      @(negedge clk_in);
      take = 1'b0;
      chk(ack, 1'b0);
      clr[4] = 1'b1;
      @(negedge clk_in);
      clr[4] = 1'b0;
      mp[4] = 0;
      wait_n(2);
      chk(pend, mp[15:0]);
      $display("test mask done");
      stop_test();
   end
endmodule : tb_ext_irq_pin_logic
`default_nettype wire
